//--- hdl/io_port_wakeup.sv
// io ports a, b, c with low-power entry and wake-up timing
//
// Contract
// - deep-stop enters power-down with all clocks off, light-stop enters power-save.
// - pin toggles wake from either state, timer and comparator only from power-save.
// - a pin wakes only when it is an input with its digital input enable set.
// - normal wake-up resumes about 3000 slow rc periods after the event.
// - fast wake-up resumes about 45 slow rc periods after the toggle.
// - misc bit 5 picks fast or normal only under normal boot, fast boot forces fast.
// - direction 0 is input, 1 drives data, enabled pull-up on unless driving low.
// - driving low switches off pull-up and pull-down.
// - data read gives pad level for inputs and stored bit for outputs.
// - only port b bits 2,3 and port c bits 0,1 have pull-downs.
// - the open-drain pin only pulls low or floats.
`include "io_port_cfg.svh"
`default_nettype none
module io_port_wakeup
    import io_port_pkg::*;
#(
    parameter int W = 8,
    parameter int NORMAL_CYC = `SLOW_CYC_NORMAL,
    parameter int FAST_CYC = `SLOW_CYC_FAST
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow_internal_rc_clock,
    input wire logic [W-1:0] port_a_data_reg,
    input wire logic [W-1:0] port_a_dir,
    input wire logic [W-1:0] port_a_pu,
    input wire logic [W-1:0] port_a_die,
    input wire logic [W-1:0] port_b_data,
    input wire logic [W-1:0] port_b_dir,
    input wire logic [W-1:0] port_b_pu,
    input wire logic [W-1:0] port_b_pd,
    input wire logic [W-1:0] port_b_die,
    input wire logic [W-1:0] port_c_data,
    input wire logic [W-1:0] port_c_dir,
    input wire logic [W-1:0] port_c_pu,
    input wire logic [W-1:0] port_c_pd,
    input wire logic [W-1:0] port_c_die,
    input wire logic [W-1:0] pad_a_in,
    input wire logic [W-1:0] pad_b_in,
    input wire logic [W-1:0] pad_c_in,
    output logic [W-1:0] pad_a_out,
    output logic [W-1:0] pad_a_oe,
    output logic [W-1:0] pad_b_out,
    output logic [W-1:0] pad_b_oe,
    output logic [W-1:0] pad_c_out,
    output logic [W-1:0] pad_c_oe,
    output logic [W-1:0] pu_a_on,
    output logic [W-1:0] pu_b_on,
    output logic [W-1:0] pu_c_on,
    output logic [W-1:0] pd_b_on,
    output logic [W-1:0] pd_c_on,
    output logic [W-1:0] rd_a,
    output logic [W-1:0] rd_b,
    output logic [W-1:0] rd_c,
    input wire logic [7:0] misc_ctrl,
    input wire logic fast_boot,
    input wire logic stop_sys,
    input wire logic stop_exe,
    input wire logic timer_wake,
    input wire logic cmp_wake,
    output logic sys_clk_en,
    output logic osc_en,
    output logic [1:0] pwr_state
);
    localparam int CW = $clog2(NORMAL_CYC + 1);
    pwr_state_t state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [CW-1:0] len_ff, nxt_len;
    logic rc1_ff, rc2_ff, rc3_ff;
    logic tw1_ff, tw2_ff, cw1_ff, cw2_ff;
    logic tog_a, tog_b, tog_c, pin_tog, rc_rise, use_fast, wake_ev;
    // ----------------------------------------
    // three ports
    // ----------------------------------------
    io_pin_cell #(.W(W), .PD_MASK(8'h00), .OD_MASK(8'h01 << `OD_PIN_IDX)) u_port_a (
        .sys_clk(sys_clk), .rst(rst), .data_reg(port_a_data_reg), .dir_reg(port_a_dir),
        .pu_reg(port_a_pu), .pd_reg('0), .die_reg(port_a_die), .pad_in(pad_a_in),
        .pad_out(pad_a_out), .pad_oe(pad_a_oe), .pu_on(pu_a_on), .pd_on(),
        .rd_data(rd_a), .toggle(tog_a)
    );
    io_pin_cell #(.W(W), .PD_MASK(`PD_MASK_B), .OD_MASK(8'h00)) u_port_b (
        .sys_clk(sys_clk), .rst(rst), .data_reg(port_b_data), .dir_reg(port_b_dir),
        .pu_reg(port_b_pu), .pd_reg(port_b_pd), .die_reg(port_b_die), .pad_in(pad_b_in),
        .pad_out(pad_b_out), .pad_oe(pad_b_oe), .pu_on(pu_b_on), .pd_on(pd_b_on),
        .rd_data(rd_b), .toggle(tog_b)
    );
    io_pin_cell #(.W(W), .PD_MASK(`PD_MASK_C), .OD_MASK(8'h00)) u_port_c (
        .sys_clk(sys_clk), .rst(rst), .data_reg(port_c_data), .dir_reg(port_c_dir),
        .pu_reg(port_c_pu), .pd_reg(port_c_pd), .die_reg(port_c_die), .pad_in(pad_c_in),
        .pad_out(pad_c_out), .pad_oe(pad_c_oe), .pu_on(pu_c_on), .pd_on(pd_c_on),
        .rd_data(rd_c), .toggle(tog_c)
    );
    assign pin_tog = tog_a | tog_b | tog_c;
    // ----------------------------------------
    // wake decision
    // ----------------------------------------
    // fast boot overrides the misc select bit
    assign use_fast = fast_boot | misc_ctrl[`FAST_SEL_BIT];
    assign rc_rise = rc2_ff & ~rc3_ff;
    // timer and comparator are ignored in deep power-down
    assign wake_ev = pin_tog | ((state_ff == st_save) & (tw2_ff | cw2_ff));
    // ----------------------------------------
    // synchronisers for async sources
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rc1_ff <= 1'b0;
            rc2_ff <= 1'b0;
            rc3_ff <= 1'b0;
            tw1_ff <= 1'b0;
            tw2_ff <= 1'b0;
            cw1_ff <= 1'b0;
            cw2_ff <= 1'b0;
        end else begin
            rc1_ff <= slow_internal_rc_clock;
            rc2_ff <= rc1_ff;
            rc3_ff <= rc2_ff;
            tw1_ff <= timer_wake;
            tw2_ff <= tw1_ff;
            cw1_ff <= cmp_wake;
            cw2_ff <= cw1_ff;
        end
    end
    // ----------------------------------------
    // power state machine and wake counter
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_len = len_ff;
        unique case (state_ff)
            st_run: begin
                if (stop_sys) begin
                    nxt_state = st_down;
                end else if (stop_exe) begin
                    nxt_state = st_save;
                end
            end
            st_save, st_down: begin
                if (wake_ev) begin
                    nxt_state = st_wait;
                    nxt_cnt = '0;
                    nxt_len = use_fast ? CW'(FAST_CYC) : CW'(NORMAL_CYC);
                end
            end
            st_wait: begin
                if (rc_rise) begin
                    if (cnt_ff == len_ff - CW'(1)) begin
                        nxt_state = st_run;
                    end else begin
                        nxt_cnt = cnt_ff + CW'(1);
                    end
                end
            end
        endcase
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff <= st_run;
            cnt_ff <= '0;
            len_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            len_ff <= nxt_len;
        end
    end
    // oscillators stay up except in deep power-down
    assign sys_clk_en = (state_ff == st_run);
    assign osc_en = (state_ff != st_down);
    assign pwr_state = state_ff;
    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_DOWN_ENTRY: assert property (@(posedge sys_clk) disable iff (rst)
        (state_ff == st_run && stop_sys) |=> (state_ff == st_down && !osc_en))
        else $error("deep stop did not stop oscillators");
    AST_SAVE_ENTRY: assert property (@(posedge sys_clk) disable iff (rst)
        (state_ff == st_run && !stop_sys && stop_exe) |=> (state_ff == st_save && osc_en))
        else $error("light stop did not enter power-save");
    AST_DOWN_IGNORE: assert property (@(posedge sys_clk) disable iff (rst)
        (state_ff == st_down && !pin_tog) |=> state_ff == st_down)
        else $error("power-down left without pin toggle");
    AST_PIN_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
        ((state_ff == st_down || state_ff == st_save) && pin_tog) |=> state_ff == st_wait)
        else $error("pin toggle did not wake");
    AST_LEN_SEL: assert property (@(posedge sys_clk) disable iff (rst)
        (state_ff != st_wait && nxt_state == st_wait && (fast_boot || misc_ctrl[5]))
        |=> len_ff == CW'(FAST_CYC))
        else $error("fast length not chosen");
    AST_LEN_NORMAL: assert property (@(posedge sys_clk) disable iff (rst)
        (state_ff != st_wait && nxt_state == st_wait && !fast_boot && !misc_ctrl[5])
        |=> len_ff == CW'(NORMAL_CYC))
        else $error("normal length not chosen");
    AST_CLK_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        (state_ff == st_wait) |-> !sys_clk_en)
        else $error("clock enabled while waking");
    AST_END_WAIT: assert property (@(posedge sys_clk) disable iff (rst)
        (state_ff == st_wait && rc_rise && cnt_ff == len_ff - CW'(1)) |=> sys_clk_en)
        else $error("clock not restored at count end");
    AST_OD_PIN: assert property (@(posedge sys_clk) disable iff (rst)
        port_a_data_reg[5] |-> !pad_a_oe[5])
        else $error("open-drain pin drove high");
    AST_LOW_PULL: assert property (@(posedge sys_clk) disable iff (rst)
        (port_b_dir[2] && !port_b_data[2]) |-> (!pu_b_on[2] && !pd_b_on[2]))
        else $error("pull left on while driving low");
    // timer and comparator must still wake the core out of power-save
    AST_SAVE_TIMER: assert property (@(posedge sys_clk) disable iff (rst)
        (state_ff == st_save && (tw2_ff || cw2_ff)) |=> state_ff == st_wait)
        else $error("timer or comparator did not wake from power-save");
    // a counter past its length would never restart the clock
    AST_CNT_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
        (state_ff == st_wait) |-> cnt_ff < len_ff)
        else $error("wake counter beyond its length");
    COV_SAVE_WAKE: cover property (@(posedge sys_clk) state_ff == st_save ##1 state_ff == st_wait);
    COV_FAST_LEN: cover property (@(posedge sys_clk) state_ff == st_wait && len_ff == CW'(FAST_CYC));
    COV_DOWN_WAKE: cover property (@(posedge sys_clk) state_ff == st_down ##1 state_ff == st_wait);
    COV_RESUME: cover property (@(posedge sys_clk) state_ff == st_wait ##1 state_ff == st_run);
endmodule // io_port_wakeup
`default_nettype wire

//--- hdl/io_port_cfg.svh
// timing constants and field positions for the io port and wake-up block
`ifndef IO_PORT_CFG_SVH
`define IO_PORT_CFG_SVH
`define SLOW_CYC_NORMAL 3000
`define SLOW_CYC_FAST 45
`define FAST_SEL_BIT 5
`define OD_PIN_IDX 5
`define PD_MASK_B 8'h0c
`define PD_MASK_C 8'h03
`define INT_MASK_A 8'h11
`define INT_MASK_B 8'h21
`endif

//--- hdl/io_port_pkg.sv
// types for the io port and wake-up block
`default_nettype none
package io_port_pkg;
    typedef enum logic [1:0] {
        st_run = 2'b00,
        st_save = 2'b01,
        st_down = 2'b11,
        st_wait = 2'b10
    } pwr_state_t;
endpackage
`default_nettype wire

//--- hdl/io_pin_cell.sv
// one port of eight pads: drive, pulls, readback and toggle detect
`default_nettype none
module io_pin_cell #(
    parameter int W = 8,
    parameter logic [7:0] PD_MASK = 8'h00,
    parameter logic [7:0] OD_MASK = 8'h00
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] data_reg,
    input wire logic [W-1:0] dir_reg,
    input wire logic [W-1:0] pu_reg,
    input wire logic [W-1:0] pd_reg,
    input wire logic [W-1:0] die_reg,
    input wire logic [W-1:0] pad_in,
    output logic [W-1:0] pad_out,
    output logic [W-1:0] pad_oe,
    output logic [W-1:0] pu_on,
    output logic [W-1:0] pd_on,
    output logic [W-1:0] rd_data,
    output logic toggle
);
    logic [W-1:0] s1_ff, s2_ff, s3_ff;
    logic [W-1:0] nxt_s1, nxt_s2, nxt_s3;
    genvar i;
    // ----------------------------------------
    // per-pin combinational pad control
    // ----------------------------------------
    generate
        for (i = 0; i < W; i++) begin : g_pin
            logic drive_low;
            assign drive_low = dir_reg[i] & ~data_reg[i];
            assign pad_out[i] = data_reg[i];
            // open-drain pin has no high side, so it floats when high
            assign pad_oe[i] = dir_reg[i] & (~OD_MASK[i] | ~data_reg[i]);
            assign pu_on[i] = pu_reg[i] & ~drive_low;
            assign pd_on[i] = PD_MASK[i] & pd_reg[i] & ~drive_low;
            assign rd_data[i] = dir_reg[i] ? data_reg[i] : s2_ff[i];
        end
    endgenerate
    // toggle only from digital inputs with enabled input path
    assign toggle = |((s2_ff ^ s3_ff) & ~dir_reg & die_reg);
    // ----------------------------------------
    // pad synchroniser
    // ----------------------------------------
    always_comb begin
        nxt_s1 = pad_in;
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
        end
    end
endmodule // io_pin_cell
`default_nettype wire

//--- verification/pad_board_model.sv
// board side of eight pads: device drivers, board drivers, pulls, floating nodes
`default_nettype none
module pad_board_model (
    input wire logic clk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pu_on,
    input wire logic [7:0] pd_on,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pad_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] float_ff = 8'h55;
    // an undriven node wobbles, so a stale level never passes by luck
    always @(posedge clk) float_ff <= ~float_ff;
    // device driver wins, then the board, then the weak pulls
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i]) pad_lvl[i] = pad_out[i];
            else if (ext_en[i]) pad_lvl[i] = ext_val[i];
            else if (pu_on[i]) pad_lvl[i] = 1'b1;
            else if (pd_on[i]) pad_lvl[i] = 1'b0;
            else pad_lvl[i] = float_ff[i];
        end
    end
endmodule // pad_board_model
`default_nettype wire

//--- verification/io_port_with_wakeup_bench.sv
// self-checking bench for the io port and wake-up block
`default_nettype none
module io_port_with_wakeup_bench
    import io_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // shortened wake lengths keep the run small
    localparam int NCYC = 10;
    localparam int FCYC = 3;
    logic sys_clk = 1'b0, rst = 1'b1, slow_internal_rc_clock = 1'b0;
    logic [7:0] port_a_data_reg = '0, port_a_dir = '0, port_a_pu = '0, port_a_die = '0;
    logic [7:0] port_b_data = '0, port_b_dir = '0, port_b_pu = '0, port_b_pd = '0, port_b_die = '0;
    logic [7:0] port_c_data = '0, port_c_dir = '0, port_c_pu = '0, port_c_pd = '0, port_c_die = '0;
    logic [7:0] misc_ctrl = '0, ea_val = '0, ea_en = 8'hff, eb_en = '0, ec_en = '0;
    logic fast_boot = 1'b0, stop_sys = 1'b0, stop_exe = 1'b0, timer_wake = 1'b0, cmp_wake = 1'b0;
    logic [7:0] pad_a_in, pad_b_in, pad_c_in, pad_a_out, pad_a_oe, pad_b_out, pad_b_oe;
    logic [7:0] pad_c_out, pad_c_oe, pu_a_on, pu_b_on, pu_c_on, pd_b_on, pd_c_on;
    logic [7:0] rd_a, rd_b, rd_c;
    logic sys_clk_en, osc_en;
    logic [1:0] pwr_state;
    int n_errors = 0, checks_done = 0;
    // 50 ns system clock, 400 ns slow rc clock
    always #25 sys_clk = ~sys_clk;
    always #200 slow_internal_rc_clock = ~slow_internal_rc_clock;
    io_port_wakeup #(.NORMAL_CYC(NCYC), .FAST_CYC(FCYC)) dut (
        .sys_clk, .rst, .slow_internal_rc_clock, .port_a_data_reg, .port_a_dir, .port_a_pu,
        .port_a_die, .port_b_data, .port_b_dir, .port_b_pu, .port_b_pd, .port_b_die,
        .port_c_data, .port_c_dir, .port_c_pu, .port_c_pd, .port_c_die, .pad_a_in, .pad_b_in,
        .pad_c_in, .pad_a_out, .pad_a_oe, .pad_b_out, .pad_b_oe, .pad_c_out, .pad_c_oe,
        .pu_a_on, .pu_b_on, .pu_c_on, .pd_b_on, .pd_c_on, .rd_a, .rd_b, .rd_c, .misc_ctrl,
        .fast_boot, .stop_sys, .stop_exe, .timer_wake, .cmp_wake, .sys_clk_en, .osc_en,
        .pwr_state);
    // one board model per port; port a has no pull-downs
    pad_board_model pm_a (.clk(sys_clk), .pad_out(pad_a_out), .pad_oe(pad_a_oe),
        .pu_on(pu_a_on), .pd_on(8'h00), .ext_val(ea_val), .ext_en(ea_en), .pad_lvl(pad_a_in));
    pad_board_model pm_b (.clk(sys_clk), .pad_out(pad_b_out), .pad_oe(pad_b_oe),
        .pu_on(pu_b_on), .pd_on(pd_b_on), .ext_val(8'h00), .ext_en(eb_en), .pad_lvl(pad_b_in));
    pad_board_model pm_c (.clk(sys_clk), .pad_out(pad_c_out), .pad_oe(pad_c_oe),
        .pu_on(pu_c_on), .pd_on(pd_c_on), .ext_val(8'h00), .ext_en(ec_en), .pad_lvl(pad_c_in));
    // ----
    // compare and closing tasks
    // ----
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // static pin setup: drivers, pulls and readback on all three ports
    task automatic t_pins;
        @(negedge sys_clk);
        port_a_dir = 8'h2f;
        port_a_data_reg = 8'h25;
        port_a_pu = 8'hff;
        ea_en = 8'hd0;
        ea_val = 8'h90;
        port_b_dir = 8'h0f;
        port_b_data = 8'h05;
        port_b_pu = 8'hff;
        port_b_pd = 8'hff;
        port_b_die = 8'h21;
        port_c_pd = 8'hff;
        port_c_pu = 8'hfc;
        // port c stands in for analog pins, input path off
        port_c_die = 8'h00;
        repeat (4) @(negedge sys_clk);
        chk8(pad_a_out, 8'h25);
        chk8(pad_b_oe, 8'h0f);
        chk8(pad_b_out, 8'h05);
        chk8(pad_c_oe, 8'h00);
        chk8(pad_c_out, 8'h00);
        chk8(pu_c_on, 8'hfc);
        chk8(rd_c, 8'hfc);
        chk8(pad_a_oe, 8'h0f);
        chk8(rd_a, 8'hb5);
        chk8(pu_a_on, 8'hf5);
        chk8(pu_b_on, 8'hf5);
        chk8(pd_b_on, 8'h04);
        chk8(pd_c_on, 8'h03);
        chk8(rd_b, 8'hf5);
        ea_en = 8'hff;
        ea_val = 8'h00;
        port_a_dir = 8'h00;
        // pins 0 and 4 double as interrupt inputs
        port_a_die = 8'h11;
    endtask
    // stop, refused events, then one wake source and the resume latency
    task automatic t_wake(input logic deep, input logic fb, input logic m5, input int src,
            input int len);
        int n;
        @(negedge sys_clk);
        fast_boot = fb;
        misc_ctrl = {2'b00, m5, 5'h00};
        repeat (4) @(negedge sys_clk);
        if (deep) stop_sys = 1'b1;
        else stop_exe = 1'b1;
        @(negedge sys_clk);
        stop_sys = 1'b0;
        stop_exe = 1'b0;
        chk8({6'h00, pwr_state}, deep ? 8'h03 : 8'h01);
        chk1(osc_en, !deep);
        chk1(sys_clk_en, 1'b0);
        // pin 1 has its input enable off; timer and comparator only in deep
        ea_val = 8'h02;
        // an output pin with its input enable set must not wake either
        port_b_data = port_b_data ^ 8'h01;
        timer_wake = deep;
        cmp_wake = deep;
        repeat (10) @(negedge sys_clk);
        chk8({6'h00, pwr_state}, deep ? 8'h03 : 8'h01);
        if (src == 0) ea_val = 8'h03;
        else if (src == 1) timer_wake = 1;
        else cmp_wake = 1;
        n = 0;
        while (sys_clk_en !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 2000) begin
            n_errors++;
            report_and_stop;
        end
        chk1(n >= (len - 1) * 8 && n <= (len + 2) * 8, 1'b1);
        chk8({6'h00, pwr_state}, 8'h00);
        timer_wake = 0;
        cmp_wake = 0;
        ea_val = 8'h00;
    endtask
    // main sequence
    initial begin
        repeat (3) @(negedge sys_clk);
        chk1(sys_clk_en, 1'b1);
        chk1(osc_en, 1'b1);
        chk8({6'h00, pwr_state}, 8'h00);
        chk8(rd_a, 8'h00);
        @(negedge sys_clk);
        rst = 1'b0;
        t_pins;
        t_wake(1, 0, 0, 0, NCYC);
        t_wake(0, 0, 1, 0, FCYC);
        t_wake(1, 1, 0, 0, FCYC);
        t_wake(0, 0, 0, 1, NCYC);
        t_wake(0, 0, 0, 2, NCYC);
        report_and_stop;
    end
endmodule // io_port_with_wakeup_bench
`default_nettype wire
